// >>> verilog/tps_pkg.sv
package tps_pkg;
	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_OPTION_B1 = 9'h081;
	localparam logic [8:0] IDX_OPTION_B3 = 9'h181;
	localparam logic [8:0] IDX_TIMER0 = 9'h101;
	localparam logic [8:0] IDX_INTERRUPT_CONTROL_B0 = 9'h00b;
	localparam logic [8:0] IDX_INTERRUPT_CONTROL_B1 = 9'h08b;
	localparam logic [8:0] IDX_INTERRUPT_CONTROL_B2 = 9'h10b;
	localparam logic [8:0] IDX_INTERRUPT_CONTROL_B3 = 9'h18b;
	localparam logic [8:0] IDX_IRQ_STATUS = 9'h1f0;
	localparam logic [8:0] IDX_IRQ_MASK = 9'h1f1;

	// option register fields
	localparam int OPT_PULLUP_DIS = 7;
	localparam int OPT_INT_EDGE = 6;
	localparam int OPT_T0_SRC = 5;
	localparam int OPT_T0_EDGE = 4;
	localparam int OPT_PS_ASSIGN = 3;
	localparam int OPT_RATE_HI = 2;

	// interrupt control fields
	localparam int IC_T0_FLAG = 2;
	localparam int IC_EXT_FLAG = 1;

	// sticky event bits
	localparam int EV_T0_OVF = 0;
	localparam int EV_EXT_INT = 1;
	localparam int EV_WDT_TICK = 2;
	localparam int EV_W = 3;

	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER0_RESET = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;

	typedef enum logic [1:0] {
		TPS_IDLE = 2'b01,
		TPS_ACK = 2'b10
	} tps_bus_t;

	typedef struct packed {
		tps_bus_t bus;
		logic [31:0] rdata;
		logic [7:0] option;
		logic [7:0] timer0;
		logic [7:0] interrupt_control;
		logic [7:0] ps_cnt;
		logic ext_clk_q;
		logic ext_int_q;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_mask;
		logic [7:0] pullup_en;
		logic wdt_tick;
	} tps_state_t;
endpackage

// >>> verilog/tps_timer0.sv
`timescale 1ns/1ps
// What this block does
// - one prescaler shared; assign bit 3 set gives it to watchdog, clear to timer0
// - rate field 000 gives timer0 1:2 or watchdog 1:1, doubling per step
// - clock source bit 5 set counts pin edges, clear counts instruction cycles
// - source edge bit 4 set counts falling pin edges, clear counts rising ones
// - interrupt edge bit 6 set triggers on rising edge, clear on falling edge
// - bit 7 set disables all pull-ups; clear lets each pin's setting decide
// - option register fully read/write, resets to all ones
// - option register seen at two bank addresses sharing one storage
// - interrupt control register reachable from every bank, resets to zero
module tps_timer0 (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [10:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic instruction_cycle_clock,
	input wire logic timer0_ext_clock_pin,
	input wire logic ext_interrupt_pin,
	input wire logic watchdog_timer_raw_tick,
	input wire logic [7:0] port_direction,
	output logic watchdog_timer_tick,
	output logic [7:0] port_pullup_en,
	output logic irq
);
	tps_pkg::tps_state_t st;
	tps_pkg::tps_state_t next_st;

	function automatic logic is_interrupt_control(input logic [8:0] idx);
		is_interrupt_control = (idx == tps_pkg::IDX_INTERRUPT_CONTROL_B0) || (idx == tps_pkg::IDX_INTERRUPT_CONTROL_B1) ||
			(idx == tps_pkg::IDX_INTERRUPT_CONTROL_B2) || (idx == tps_pkg::IDX_INTERRUPT_CONTROL_B3);
	endfunction

	function automatic logic is_option(input logic [8:0] idx);
		is_option = (idx == tps_pkg::IDX_OPTION_B1) || (idx == tps_pkg::IDX_OPTION_B3);
	endfunction

	// low bits of the prescaler that must all be ones before a tick passes
	function automatic logic [7:0] ps_mask(input logic [2:0] rate, input logic to_wdt);
		if (to_wdt) begin
			ps_mask = tps_pkg::BYTE_ONES >> (4'd8 - {1'b0, rate});
		end else begin
			ps_mask = tps_pkg::BYTE_ONES >> (3'd7 - rate);
		end
	endfunction

	localparam int EV_W_HI = tps_pkg::EV_W - 1;

	logic [8:0] idx;
	logic req;
	logic wr_go;
	logic [7:0] wbyte;
	logic ext_clk_rise;
	logic ext_clk_fall;
	logic t0_src_ev;
	logic ps_src_ev;
	logic ps_tick;
	logic [7:0] mask;
	logic t0_inc;
	logic ext_int_ev;
	logic t0_ovf_ev;
	logic to_wdt;

	assign idx = avs_address[10:2];
	assign req = avs_read || avs_write;
	assign wr_go = avs_write && (st.bus == tps_pkg::TPS_ACK) && avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign to_wdt = st.option[tps_pkg::OPT_PS_ASSIGN];

	assign ext_clk_rise = timer0_ext_clock_pin && !st.ext_clk_q;
	assign ext_clk_fall = !timer0_ext_clock_pin && st.ext_clk_q;

	always_comb begin
		// source edge selects which pin transition counts
		if (st.option[tps_pkg::OPT_T0_SRC]) begin
			t0_src_ev = st.option[tps_pkg::OPT_T0_EDGE] ? ext_clk_fall : ext_clk_rise;
		end else begin
			t0_src_ev = instruction_cycle_clock;
		end
	end

	// shared prescaler: fed by the watchdog or by the timer0 source
	assign ps_src_ev = to_wdt ? watchdog_timer_raw_tick : t0_src_ev;
	assign mask = ps_mask(st.option[tps_pkg::OPT_RATE_HI:0], to_wdt);
	assign ps_tick = ps_src_ev && ((st.ps_cnt & mask) == mask);
	// with the prescaler on the watchdog, timer0 runs undivided
	assign t0_inc = to_wdt ? t0_src_ev : ps_tick;
	assign t0_ovf_ev = t0_inc && (st.timer0 == tps_pkg::BYTE_ONES);

	assign ext_int_ev = st.option[tps_pkg::OPT_INT_EDGE] ?
		(ext_interrupt_pin && !st.ext_int_q) : (!ext_interrupt_pin && st.ext_int_q);

	always_comb begin
		next_st = st;
		next_st.ext_clk_q = timer0_ext_clock_pin;
		next_st.ext_int_q = ext_interrupt_pin;
		next_st.wdt_tick = to_wdt ? ps_tick : watchdog_timer_raw_tick;
		next_st.pullup_en = st.option[tps_pkg::OPT_PULLUP_DIS] ? 8'h00 : port_direction;

		if (ps_src_ev) begin
			next_st.ps_cnt = st.ps_cnt + 8'h01;
		end
		if (t0_inc) begin
			next_st.timer0 = st.timer0 + 8'h01;
		end

		// bus handshake: one wait cycle, then the answer
		case (st.bus)
			tps_pkg::TPS_IDLE: begin
				if (req) begin
					next_st.bus = tps_pkg::TPS_ACK;
				end
				next_st.rdata = 32'h0000_0000;
				if (is_option(idx)) begin
					next_st.rdata[7:0] = st.option;
				end else if (idx == tps_pkg::IDX_TIMER0) begin
					next_st.rdata[7:0] = st.timer0;
				end else if (is_interrupt_control(idx)) begin
					next_st.rdata[7:0] = st.interrupt_control;
				end else if (idx == tps_pkg::IDX_IRQ_STATUS) begin
					next_st.rdata[EV_W_HI:0] = st.irq_status;
				end else if (idx == tps_pkg::IDX_IRQ_MASK) begin
					next_st.rdata[EV_W_HI:0] = st.irq_mask;
				end
			end
			tps_pkg::TPS_ACK: begin
				next_st.bus = tps_pkg::TPS_IDLE;
			end
			default: begin
				next_st.bus = tps_pkg::TPS_IDLE;
			end
		endcase

		if (wr_go) begin
			if (is_option(idx)) begin
				next_st.option = wbyte;
			end else if (idx == tps_pkg::IDX_TIMER0) begin
				// a write restarts the count; it clears the shared prescaler only while the prescaler is assigned to timer0
				next_st.timer0 = wbyte;
				if (!to_wdt) begin
					next_st.ps_cnt = 8'h00;
				end
			end else if (is_interrupt_control(idx)) begin
				next_st.interrupt_control = wbyte;
			end else if (idx == tps_pkg::IDX_IRQ_MASK) begin
				next_st.irq_mask = wbyte[EV_W_HI:0];
			end
		end

		// hardware sets win over a software write in the same cycle
		if (t0_ovf_ev) begin
			next_st.interrupt_control[tps_pkg::IC_T0_FLAG] = 1'b1;
		end
		if (ext_int_ev) begin
			next_st.interrupt_control[tps_pkg::IC_EXT_FLAG] = 1'b1;
		end
		if (wr_go && (idx == tps_pkg::IDX_IRQ_STATUS)) begin
			next_st.irq_status = st.irq_status & ~wbyte[EV_W_HI:0];
		end
		next_st.irq_status[tps_pkg::EV_T0_OVF] = next_st.irq_status[tps_pkg::EV_T0_OVF] | t0_ovf_ev;
		next_st.irq_status[tps_pkg::EV_EXT_INT] = next_st.irq_status[tps_pkg::EV_EXT_INT] | ext_int_ev;
		next_st.irq_status[tps_pkg::EV_WDT_TICK] = next_st.irq_status[tps_pkg::EV_WDT_TICK] | next_st.wdt_tick;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st.bus <= tps_pkg::TPS_IDLE;
			st.rdata <= 32'h0000_0000;
			st.option <= tps_pkg::OPTION_RESET;
			st.timer0 <= tps_pkg::TIMER0_RESET;
			st.interrupt_control <= tps_pkg::INTERRUPT_CONTROL_RESET;
			st.ps_cnt <= 8'h00;
			st.ext_clk_q <= 1'b0;
			st.ext_int_q <= 1'b0;
			st.irq_status <= '0;
			st.irq_mask <= '0;
			st.pullup_en <= 8'h00;
			st.wdt_tick <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign avs_waitrequest = req && (st.bus == tps_pkg::TPS_IDLE);
	assign avs_readdata = st.rdata;
	assign watchdog_timer_tick = st.wdt_tick;
	assign port_pullup_en = st.pullup_en;
	assign irq = |(st.irq_status & st.irq_mask);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_bus_one_wait: assert property (req && st.bus == tps_pkg::TPS_IDLE |-> avs_waitrequest ##1
		(!avs_waitrequest || !req))
		else $error("bus answer not given after one wait cycle");
	a_option_alias: assert property (
		wr_go && idx == tps_pkg::IDX_OPTION_B3 |=> st.option == $past(wbyte))
		else $error("option write at second bank not stored");
	a_option_read: assert property (
		avs_read && !avs_waitrequest && idx == tps_pkg::IDX_OPTION_B1 && !$past(wr_go) |->
		avs_readdata[7:0] == st.option)
		else $error("option read back wrong");
	a_interrupt_control_banks: assert property (
		wr_go && idx == tps_pkg::IDX_INTERRUPT_CONTROL_B0 && !t0_ovf_ev && !ext_int_ev |=> st.interrupt_control == $past(wbyte))
		else $error("interrupt control not reachable from bank 0");
	a_t0_wrap_flag: assert property (
		t0_inc && st.timer0 == tps_pkg::BYTE_ONES && !wr_go |=>
		st.timer0 == 8'h00 && st.interrupt_control[tps_pkg::IC_T0_FLAG] && st.irq_status[tps_pkg::EV_T0_OVF])
		else $error("timer0 wrap did not set overflow flag");
	a_t0_undivided: assert property (
		to_wdt && t0_src_ev && !wr_go |=> st.timer0 == $past(st.timer0) + 8'h01)
		else $error("timer0 not undivided with prescaler on watchdog");
	a_rate_min: assert property (
		!to_wdt && st.option[2:0] == 3'b000 && t0_src_ev && !st.ps_cnt[0] |-> !t0_inc)
		else $error("timer0 ratio 1:2 ticked on first event");
	a_wdt_bypass: assert property (
		!to_wdt && watchdog_timer_raw_tick |=> watchdog_timer_tick)
		else $error("watchdog tick lost while prescaler on timer0");
	a_ext_fall: assert property (
		st.option[tps_pkg::OPT_T0_SRC] && st.option[tps_pkg::OPT_T0_EDGE] && ext_clk_rise |-> !t0_src_ev)
		else $error("rising pin edge counted in falling mode");
	a_src_internal: assert property (
		!st.option[tps_pkg::OPT_T0_SRC] |-> t0_src_ev == instruction_cycle_clock)
		else $error("internal clock source not followed");
	a_int_edge: assert property (
		st.option[tps_pkg::OPT_INT_EDGE] && ext_interrupt_pin && !st.ext_int_q |=>
		st.interrupt_control[tps_pkg::IC_EXT_FLAG] ##0 irq == |(st.irq_status & st.irq_mask))
		else $error("rising edge did not set external flag");
	a_pullup_off: assert property (
		st.option[tps_pkg::OPT_PULLUP_DIS] && $past(st.option[tps_pkg::OPT_PULLUP_DIS]) |-> port_pullup_en == 8'h00)
		else $error("pull-ups not disabled");

	c_t0_wrap: cover property (t0_ovf_ev ##1 irq);
	c_ext_int: cover property (ext_int_ev ##1 st.interrupt_control[tps_pkg::IC_EXT_FLAG]);
	c_wdt_div: cover property (to_wdt && st.option[2:0] != 3'b000 && ps_tick);
	c_bus_write: cover property (wr_go && is_option(idx));
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, ic, t0p, intp, wraw, wtick, irq;
	logic [10:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] be;
	logic [7:0] pdir, pull;
	int failures, tests_run, wseen;
	tps_timer0 u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instruction_cycle_clock(ic),
		.timer0_ext_clock_pin(t0p), .ext_interrupt_pin(intp), .watchdog_timer_raw_tick(wraw),
		.port_direction(pdir), .watchdog_timer_tick(wtick), .port_pullup_en(pull), .irq(irq));
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		if (wtick === 1'b1) wseen++;
	end
	task automatic stop_test;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// master: holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		// waitrequest and read data are taken as they stand at the rising edge
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 16);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// one idle edge so the next request never reassigns in this time step
		@(posedge clk_sys);
		if (n >= 16) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic rdc(input logic [8:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	task automatic pls(input int s, input int n);
		repeat (n) begin
			ic <= (s == 0);
			wraw <= (s == 1);
			@(posedge clk_sys);
			ic <= 1'b0;
			wraw <= 1'b0;
			@(posedge clk_sys);
		end
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic setp(input int s, input logic v);
		if (s == 0) t0p <= v;
		else intp <= v;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic see(input int s, input logic [7:0] e);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(s ? {24'h0, pull} : {31'h0, irq}, {24'h0, e});
		@(posedge clk_sys);
	endtask
	task automatic t_regs;
		rdc(9'h081, 8'hff);
		rdc(9'h10b, 8'h00);
		see(1, 8'h00);
		bus(1, 9'h181, 8'h5a);
		rdc(9'h081, 8'h5a);
		be <= 4'he;
		bus(1, 9'h081, 8'h33);
		be <= 4'hf;
		rdc(9'h181, 8'h5a);
		bus(1, 9'h10b, 8'hf8);
		rdc(9'h00b, 8'hf8);
		rdc(9'h08b, 8'hf8);
		rdc(9'h18b, 8'hf8);
		bus(1, 9'h100, 8'h77);
		rdc(9'h100, 8'h00);
		bus(1, 9'h00b, 8'h00);
		$display("regs done");
	endtask
	task automatic t_rate;
		for (int r = 0; r < 4; r++) begin
			bus(1, 9'h081, 8'(r));
			bus(1, 9'h101, 8'h00);
			pls(0, (8 << r) - 1);
			rdc(9'h101, 8'h03);
		end
		for (int r = 0; r < 8; r++) begin
			bus(1, 9'h081, 8'h00);
			bus(1, 9'h101, 8'h00);
			bus(1, 9'h081, 8'h08 | 8'(r));
			wseen = 0;
			pls(1, 3 << r);
			chk(wseen, 3);
		end
		$display("rate done");
	endtask
	task automatic t_src;
		bus(1, 9'h081, 8'h28);
		bus(1, 9'h101, 8'h00);
		setp(0, 1'b1);
		pls(0, 1);
		rdc(9'h101, 8'h01);
		setp(0, 1'b0);
		rdc(9'h101, 8'h01);
		bus(1, 9'h081, 8'h38);
		setp(0, 1'b1);
		rdc(9'h101, 8'h01);
		setp(0, 1'b0);
		rdc(9'h101, 8'h02);
		bus(1, 9'h081, 8'h08);
		bus(1, 9'h101, 8'hff);
		bus(1, 9'h1f0, 8'h07);
		bus(1, 9'h1f1, 8'h01);
		pls(0, 1);
		rdc(9'h101, 8'h00);
		rdc(9'h10b, 8'h04);
		see(0, 8'h01);
		bus(1, 9'h1f0, 8'h01);
		see(0, 8'h00);
		$display("source done");
	endtask
	task automatic t_int;
		bus(1, 9'h081, 8'h48);
		bus(1, 9'h1f1, 8'h00);
		bus(1, 9'h10b, 8'h00);
		setp(1, 1'b1);
		see(0, 8'h00);
		rdc(9'h1f0, 8'h02);
		rdc(9'h10b, 8'h02);
		bus(1, 9'h1f1, 8'h02);
		see(0, 8'h01);
		bus(1, 9'h1f0, 8'h02);
		see(0, 8'h00);
		setp(1, 1'b0);
		rdc(9'h1f0, 8'h00);
		bus(1, 9'h081, 8'h08);
		setp(1, 1'b1);
		rdc(9'h1f0, 8'h00);
		setp(1, 1'b0);
		rdc(9'h1f0, 8'h02);
		bus(1, 9'h081, 8'h7f);
		see(1, 8'ha5);
		pdir <= 8'h3c;
		see(1, 8'h3c);
		bus(1, 9'h081, 8'hff);
		see(1, 8'h00);
		$display("irq done");
	endtask
	initial begin
		{nrst, avs_read, avs_write, ic, t0p, intp, wraw} = '0;
		avs_address = '0;
		avs_writedata = '0;
		be = 4'hf;
		pdir = 8'ha5;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_rate();
		t_src();
		t_int();
		stop_test();
	end
endmodule
